// [pkg/scoc_cfg.svh]
// Register offsets, field positions, reset values and timing counts
`ifndef SCOC_CFG_SVH
`define SCOC_CFG_SVH
`define SCOC_ADDR_RXCTRL 8'h0a
`define SCOC_ADDR_OSCCTRL 8'h12
`define SCOC_ADDR_FREQNUM 8'h13
`define SCOC_ADDR_BAND 8'h14
`define SCOC_ADDR_CHAN 8'h08
`define SCOC_RXCTRL_RST 8'h17
`define SCOC_JITTER_BIT 5
`define SCOC_OSCCTRL_RST 8'hf0
`define SCOC_OSC_EXT 4'h4
`define SCOC_OSC_INT 4'hf
`define SCOC_CHAN_RST 5'h05
`define SCOC_FREQNUM_RST 8'h00
`define SCOC_CHAN_MAX 5'h0a
`define SCOC_BAND_RST 3'h0
`define SCOC_BAND_RSVD 3'h7
`define SCOC_BAND4_MAX 8'h5e
`define SCOC_BAND5_MAX 8'h66
`define SCOC_CLK_MHZ 50
`define SCOC_T_LOCK_US 170
`define SCOC_T_SW_US 11
`define SCOC_T_RXTX_US 16
`define SCOC_T_TXRX_US 32
`define SCOC_CNT_LOCK (`SCOC_T_LOCK_US * `SCOC_CLK_MHZ)
`define SCOC_CNT_SW (`SCOC_T_SW_US * `SCOC_CLK_MHZ)
`define SCOC_CNT_RXTX (`SCOC_T_RXTX_US * `SCOC_CLK_MHZ)
`define SCOC_CNT_TXRX (`SCOC_T_TXRX_US * `SCOC_CLK_MHZ)
// Frequencies in units of 100 kHz
`define SCOC_F_EU 14'd8683
`define SCOC_F_NA1 14'd9060
`define SCOC_F_NA_STEP 14'd20
`define SCOC_F_B1 14'd7690
`define SCOC_F_B2 14'd8570
`define SCOC_F_B3 14'd9030
`define SCOC_F_B4 14'd7690
`define SCOC_F_B5 14'd8330
`define SCOC_F_B6 14'd9020
`define SCOC_F_RXOFS 14'd10
// Transmit frequency of the reset channel
`define SCOC_F_RST 14'd9140
`endif

// [pkg/scoc_pkg.sv]
// Types shared by the synthesizer and oscillator control block
package scoc_pkg;
    typedef enum logic [2:0] {
        SCOC_IDLE = 3'b000,
        SCOC_LOCKING = 3'b001,
        SCOC_READY = 3'b010,
        SCOC_RETUNE = 3'b011,
        SCOC_TXSTEP = 3'b100,
        SCOC_TXON = 3'b101,
        SCOC_RXSTEP = 3'b110
    } scoc_state_t;
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } scoc_bus_t;
    typedef struct packed {
        logic osc_int_on;
        logic osc_ext_ref;
        logic [3:0] load_cap_trim;
        logic jitter_on;
    } scoc_osc_t;
endpackage

// [src/scoc_freq_calc.sv]
// Target frequency from band, number and channel, in 100 kHz units
`include "scoc_cfg.svh"
module scoc_freq_calc (
    input wire logic [2:0] band_select_i,
    input wire logic [7:0] freq_number_i,
    input wire logic [4:0] channel_i,
    output logic [13:0] freq_o,
    output logic valid_o
);
    logic [13:0] num_fine;
    logic [13:0] num_coarse;
    assign num_fine = {6'h00, freq_number_i};
    assign num_coarse = 14'(freq_number_i * 10);
    always_comb begin
        freq_o = `SCOC_F_EU;
        valid_o = 1'b1;
        case (band_select_i)
            3'h0: begin
                if (channel_i == 5'h00) begin // [R7]
                    freq_o = `SCOC_F_EU;
                end else if (channel_i <= `SCOC_CHAN_MAX) begin // [R8]
                    freq_o = 14'(`SCOC_F_NA1 + `SCOC_F_NA_STEP * 14'(channel_i - 5'h01));
                end else begin
                    valid_o = 1'b0;
                end
            end
            3'h1: freq_o = `SCOC_F_B1 + num_fine; // [R9]
            3'h2: freq_o = `SCOC_F_B2 + num_fine; // [R9]
            3'h3: freq_o = `SCOC_F_B3 + num_fine; // [R9]
            3'h6: freq_o = `SCOC_F_B6 + num_fine; // [R9]
            3'h4: begin
                freq_o = `SCOC_F_B4 + num_coarse; // [R10]
                valid_o = freq_number_i <= `SCOC_BAND4_MAX;
            end
            3'h5: begin
                freq_o = `SCOC_F_B5 + num_coarse; // [R10]
                valid_o = freq_number_i <= `SCOC_BAND5_MAX;
            end
            default: valid_o = 1'b0; // [R10]
        endcase
    end
endmodule

// [src/scoc_settle_timer.sv]
// Down counter that times one settling period
module scoc_settle_timer #(
    parameter int W = 14
) (
    input wire logic mclk_i,
    input wire logic sys_rst_i,
    input wire logic start_i,
    input wire logic [W-1:0] count_i,
    output logic done_o,
    output logic busy_o
);
    logic [W-1:0] cnt_reg;
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            cnt_reg <= '0;
        end else if (start_i) begin
            cnt_reg <= count_i;
        end else if (cnt_reg != '0) begin
            cnt_reg <= cnt_reg - 1'b1;
        end
    end
    assign done_o = (cnt_reg == {{(W-1){1'b0}}, 1'b1}) && !start_i;
    assign busy_o = cnt_reg != '0;
endmodule

// [src/scoc_top.sv]
// Oscillator, jitter and synthesizer channel control
// Notes on behaviour
// R1 - Bit 5 of the receiver control register enables clock jitter; resets to 0.
// R2 - Jitter forced off during transmit and filter tuning.
// R3 - Oscillator mode 0x4 external reference, 0xF internal oscillator and regulator.
// R4 - Oscillator mode resets to 0xF, internal oscillator running.
// R5 - Software should select 0x4 when an external reference is used.
// R6 - Load trim code 0..15 maps linearly 0 to 4.5 pF, 0.3 pF steps.
// R7 - Band 0 uses channel field; channel 0 gives 868.3 MHz.
// R8 - Channels 1 to 10 give 906 MHz plus 2 MHz per step.
// R9 - Bands 1,2,3,6: base plus 0.1 MHz times frequency number.
// R10 - Bands 4,5: base plus 1 MHz steps with limits; band 7 reserved.
// R11 - Leaving idle for ready or listen enables synthesizer; settles in 170 us.
// R12 - Lock flag rises once settling completes.
// R13 - Channel change in ready or listen settles in 11 us.
// R14 - Ready and receive run 1 MHz below transmit frequency.
// R15 - Transmit start moves to transmit frequency within 16 us.
// R16 - Transmit end returns to receive frequency within 32 us.
// R17 - No lock or unlock flag during receive/transmit steps.
// R18 - Channel field write sets channel, read returns it; used in band 0.
// R19 - Effective frequency change in ready or listen retunes, then lock flag.
// R20 - Reserved band or mode writes keep previous band or mode; a reserved mode write still takes the trim field.
`include "scoc_cfg.svh"
module scoc_top #(
    parameter int CNT_LOCK = `SCOC_CNT_LOCK
) (
    input wire logic mclk_i,
    input wire logic sys_rst_i,
    input wire scoc_pkg::scoc_bus_t bus_i,
    output logic [7:0] rdata_o,
    input wire logic go_active_i,
    input wire logic go_idle_i,
    input wire logic tx_start_i,
    input wire logic tx_end_i,
    input wire logic filter_tune_i,
    output scoc_pkg::scoc_osc_t osc_o,
    output logic synth_en_o,
    output logic [13:0] synth_freq_o,
    output logic tx_ready_o,
    output logic lock_irq_o,
    output logic unlock_irq_o,
    output scoc_pkg::scoc_state_t state_o
);
    logic [7:0] rxctrl_reg;
    logic [3:0] osc_mode_reg;
    logic [3:0] trim_reg;
    logic [7:0] freq_number_reg;
    logic [2:0] band_select_reg;
    logic [4:0] channel_reg;
    logic [13:0] eff_freq_reg;
    scoc_pkg::scoc_state_t state_reg;
    scoc_pkg::scoc_state_t state_next;
    logic jitter_reg;
    logic [13:0] synth_freq_reg;
    logic [13:0] cand_freq;
    logic cand_valid;
    logic [2:0] cand_band;
    logic [7:0] cand_num;
    logic [4:0] cand_chan;
    logic tim_start;
    logic [13:0] tim_count;
    logic tim_done;
    logic tim_busy;
    logic freq_change;
    logic wr_freq;

    // Candidate settings as they would be after this write
    always_comb begin
        cand_band = band_select_reg;
        cand_num = freq_number_reg;
        cand_chan = channel_reg;
        wr_freq = 1'b0;
        if (bus_i.wr) begin
            case (bus_i.addr)
                `SCOC_ADDR_BAND: begin
                    cand_band = bus_i.wdata[2:0];
                    wr_freq = 1'b1;
                end
                `SCOC_ADDR_FREQNUM: begin
                    cand_num = bus_i.wdata;
                    wr_freq = 1'b1;
                end
                `SCOC_ADDR_CHAN: begin
                    cand_chan = bus_i.wdata[4:0];
                    wr_freq = 1'b1;
                end
                default: wr_freq = 1'b0;
            endcase
        end
    end

    scoc_freq_calc u_calc (
        .band_select_i(cand_band),
        .freq_number_i(cand_num),
        .channel_i(cand_chan),
        .freq_o(cand_freq),
        .valid_o(cand_valid)
    );

    // Reserved settings are dropped whole so the radio never sits off-grid
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            band_select_reg <= `SCOC_BAND_RST;
            freq_number_reg <= `SCOC_FREQNUM_RST;
            channel_reg <= `SCOC_CHAN_RST;
            eff_freq_reg <= `SCOC_F_RST;
        end else if (wr_freq && cand_valid) begin // [R20]
            band_select_reg <= cand_band;
            freq_number_reg <= cand_num;
            channel_reg <= cand_chan; // [R18]
            eff_freq_reg <= cand_freq;
        end
    end
    assign freq_change = wr_freq && cand_valid && (cand_freq != eff_freq_reg);

    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            rxctrl_reg <= `SCOC_RXCTRL_RST;
        end else if (bus_i.wr && bus_i.addr == `SCOC_ADDR_RXCTRL) begin
            rxctrl_reg <= bus_i.wdata; // [R1]
        end
    end

    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            osc_mode_reg <= 4'(`SCOC_OSCCTRL_RST >> 4); // [R4]
            trim_reg <= 4'(`SCOC_OSCCTRL_RST);
        end else if (bus_i.wr && bus_i.addr == `SCOC_ADDR_OSCCTRL) begin
            trim_reg <= bus_i.wdata[3:0]; // [R6]
            if (bus_i.wdata[7:4] == `SCOC_OSC_EXT || bus_i.wdata[7:4] == `SCOC_OSC_INT) begin // [R20]
                osc_mode_reg <= bus_i.wdata[7:4];
            end
        end
    end

    always_comb begin
        case (bus_i.addr)
            `SCOC_ADDR_RXCTRL: rdata_o = rxctrl_reg;
            `SCOC_ADDR_OSCCTRL: rdata_o = {osc_mode_reg, trim_reg};
            `SCOC_ADDR_FREQNUM: rdata_o = freq_number_reg;
            `SCOC_ADDR_BAND: rdata_o = {5'h00, band_select_reg};
            `SCOC_ADDR_CHAN: rdata_o = {3'h0, channel_reg}; // [R18]
            default: rdata_o = 8'h00;
        endcase
    end

    // Radio state sequencing
    always_comb begin
        state_next = state_reg;
        tim_start = 1'b0;
        tim_count = 14'(CNT_LOCK);
        if (go_idle_i) begin
            state_next = scoc_pkg::SCOC_IDLE;
        end else begin
            case (state_reg)
                scoc_pkg::SCOC_IDLE: if (go_active_i) begin
                    state_next = scoc_pkg::SCOC_LOCKING; // [R11]
                    tim_start = 1'b1;
                end
                scoc_pkg::SCOC_LOCKING, scoc_pkg::SCOC_RETUNE: begin
                    if (freq_change) begin
                        state_next = scoc_pkg::SCOC_RETUNE;
                        tim_start = 1'b1;
                        tim_count = 14'(`SCOC_CNT_SW);
                    end else if (tim_done) begin
                        state_next = scoc_pkg::SCOC_READY;
                    end
                end
                scoc_pkg::SCOC_READY: begin
                    if (tx_start_i) begin
                        state_next = scoc_pkg::SCOC_TXSTEP; // [R15]
                        tim_start = 1'b1;
                        tim_count = 14'(`SCOC_CNT_RXTX);
                    end else if (freq_change) begin
                        state_next = scoc_pkg::SCOC_RETUNE; // [R13] [R19]
                        tim_start = 1'b1;
                        tim_count = 14'(`SCOC_CNT_SW);
                    end
                end
                scoc_pkg::SCOC_TXSTEP: if (tim_done) begin
                    state_next = scoc_pkg::SCOC_TXON;
                end
                scoc_pkg::SCOC_TXON: if (tx_end_i) begin
                    state_next = scoc_pkg::SCOC_RXSTEP; // [R16]
                    tim_start = 1'b1;
                    tim_count = 14'(`SCOC_CNT_TXRX);
                end
                scoc_pkg::SCOC_RXSTEP: if (tim_done) begin
                    state_next = scoc_pkg::SCOC_READY;
                end
                default: state_next = scoc_pkg::SCOC_IDLE;
            endcase
        end
    end

    scoc_settle_timer #(.W(14)) u_timer (
        .mclk_i(mclk_i),
        .sys_rst_i(sys_rst_i),
        .start_i(tim_start),
        .count_i(tim_count),
        .done_o(tim_done),
        .busy_o(tim_busy)
    );

    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            state_reg <= scoc_pkg::SCOC_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    // Lock pulses only at the end of a lock or retune; tx steps stay silent
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            lock_irq_o <= 1'b0;
        end else begin
            lock_irq_o <= tim_done && !go_idle_i && !freq_change &&
                (state_reg == scoc_pkg::SCOC_LOCKING || state_reg == scoc_pkg::SCOC_RETUNE); // [R12] [R17] [R19]
        end
    end
    assign unlock_irq_o = 1'b0; // [R17]

    // Receive side runs 1 MHz below transmit
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            synth_freq_reg <= 14'd0;
        end else if (state_next == scoc_pkg::SCOC_TXSTEP || state_next == scoc_pkg::SCOC_TXON) begin
            synth_freq_reg <= eff_freq_reg; // [R15]
        end else begin
            synth_freq_reg <= 14'(eff_freq_reg - `SCOC_F_RXOFS); // [R14] [R16]
        end
    end
    assign synth_freq_o = synth_freq_reg;
    assign synth_en_o = state_reg != scoc_pkg::SCOC_IDLE; // [R11]
    assign tx_ready_o = state_reg == scoc_pkg::SCOC_TXON;
    assign state_o = state_reg;

    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            jitter_reg <= 1'b0;
        end else begin
            jitter_reg <= rxctrl_reg[`SCOC_JITTER_BIT] && !filter_tune_i && // [R1]
                state_next != scoc_pkg::SCOC_TXSTEP && state_next != scoc_pkg::SCOC_TXON; // [R2]
        end
    end

    // Load trim is passed straight to the capacitor array, code n = 0.3 pF * n
    assign osc_o.load_cap_trim = trim_reg; // [R6]
    assign osc_o.osc_int_on = osc_mode_reg == `SCOC_OSC_INT; // [R3]
    assign osc_o.osc_ext_ref = osc_mode_reg == `SCOC_OSC_EXT; // [R3] [R5]
    assign osc_o.jitter_on = jitter_reg;

    property p_lock_time;
        @(posedge mclk_i) disable iff (sys_rst_i)
        (state_reg == scoc_pkg::SCOC_IDLE && state_next == scoc_pkg::SCOC_LOCKING) |->
        ##1 (!lock_irq_o) [*8];
    endproperty
    a_lock_time: assert property (p_lock_time) else $error("lock raised too early"); // [R11]
    property p_lock_ready;
        @(posedge mclk_i) disable iff (sys_rst_i)
        lock_irq_o |-> state_reg == scoc_pkg::SCOC_READY;
    endproperty
    a_lock_ready: assert property (p_lock_ready) else $error("lock without ready state"); // [R12]
    property p_no_lock_tx;
        @(posedge mclk_i) disable iff (sys_rst_i)
        (state_reg == scoc_pkg::SCOC_TXSTEP || state_reg == scoc_pkg::SCOC_RXSTEP) |-> ##1 !lock_irq_o;
    endproperty
    a_no_lock_tx: assert property (p_no_lock_tx) else $error("lock during tx step"); // [R17]
    property p_jitter_tx;
        @(posedge mclk_i) disable iff (sys_rst_i)
        (state_reg == scoc_pkg::SCOC_TXON) |-> !osc_o.jitter_on;
    endproperty
    a_jitter_tx: assert property (p_jitter_tx) else $error("jitter on during tx"); // [R2]
    property p_jitter_en;
        @(posedge mclk_i) disable iff (sys_rst_i)
        (!rxctrl_reg[`SCOC_JITTER_BIT]) |=> !osc_o.jitter_on;
    endproperty
    a_jitter_en: assert property (p_jitter_en) else $error("jitter on while disabled"); // [R1]
    property p_tx_offset;
        @(posedge mclk_i) disable iff (sys_rst_i)
        (state_reg == scoc_pkg::SCOC_READY && state_next == scoc_pkg::SCOC_READY) |=>
        synth_freq_o == 14'($past(eff_freq_reg) - `SCOC_F_RXOFS);
    endproperty
    a_tx_offset: assert property (p_tx_offset) else $error("rx offset wrong"); // [R14]
    property p_txstep;
        @(posedge mclk_i) disable iff (sys_rst_i || go_idle_i)
        (state_reg == scoc_pkg::SCOC_READY && tx_start_i) |-> ##[1:801] tx_ready_o;
    endproperty
    a_txstep: assert property (p_txstep) else $error("tx step too slow"); // [R15]
    // Return step is longer than a delay range can span, so it is counted here
    logic [10:0] rxstep_cnt;
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i || state_reg != scoc_pkg::SCOC_RXSTEP) begin
            rxstep_cnt <= 11'h000;
        end else begin
            rxstep_cnt <= rxstep_cnt + 11'h001;
        end
    end
    property p_rxstep;
        @(posedge mclk_i) disable iff (sys_rst_i)
        (state_reg == scoc_pkg::SCOC_RXSTEP) |-> rxstep_cnt < 11'(`SCOC_CNT_TXRX);
    endproperty
    a_rxstep: assert property (p_rxstep) else $error("rx step too slow"); // [R16]
    property p_timer_idle;
        @(posedge mclk_i) disable iff (sys_rst_i)
        (state_reg == scoc_pkg::SCOC_READY || state_reg == scoc_pkg::SCOC_TXON) |-> !tim_busy;
    endproperty
    a_timer_idle: assert property (p_timer_idle) else $error("settle timer running in steady state"); // [R13]
    property p_mode_legal;
        @(posedge mclk_i) disable iff (sys_rst_i)
        osc_o.osc_int_on || osc_o.osc_ext_ref;
    endproperty
    a_mode_legal: assert property (p_mode_legal) else $error("reserved osc mode"); // [R20]
    c_lock: cover property (@(posedge mclk_i) disable iff (sys_rst_i) lock_irq_o);
    c_tx: cover property (@(posedge mclk_i) disable iff (sys_rst_i) tx_ready_o);
    c_retune: cover property (@(posedge mclk_i) disable iff (sys_rst_i) state_reg == scoc_pkg::SCOC_RETUNE);
endmodule

// [tb/testbench.sv]
// Self-checking bench for the oscillator, jitter and synthesizer control block
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    scoc_pkg::scoc_bus_t bus_i = '0;
    logic [7:0] rdata_o;
    logic go_active_i = 1'b0;
    logic go_idle_i = 1'b0;
    logic tx_start_i = 1'b0;
    logic tx_end_i = 1'b0;
    logic filter_tune_i = 1'b0;
    scoc_pkg::scoc_osc_t osc_o;
    logic synth_en_o;
    logic [13:0] synth_freq_o;
    logic tx_ready_o;
    logic lock_irq_o;
    logic unlock_irq_o;
    scoc_pkg::scoc_state_t state_o;
    int err_total = 0;
    int check_count = 0;
    logic [7:0] rv;
    int n;
    int hits;

    always #10 mclk_i = ~mclk_i;

    // Short lock count keeps the run small; retune and step counts stay at full length
    scoc_top #(.CNT_LOCK(50)) scoc_top_i (
        .mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .bus_i(bus_i), .rdata_o(rdata_o),
        .go_active_i(go_active_i), .go_idle_i(go_idle_i), .tx_start_i(tx_start_i),
        .tx_end_i(tx_end_i), .filter_tune_i(filter_tune_i), .osc_o(osc_o),
        .synth_en_o(synth_en_o), .synth_freq_o(synth_freq_o), .tx_ready_o(tx_ready_o),
        .lock_irq_o(lock_irq_o), .unlock_irq_o(unlock_irq_o), .state_o(state_o)
    );

    task end_sim;
        if (err_total == 0 && check_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task chk(input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp) begin
            err_total++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge mclk_i);
        bus_i.wr = 1'b1;
        bus_i.addr = a;
        bus_i.wdata = d;
        @(negedge mclk_i);
        bus_i.wr = 1'b0;
    endtask

    task rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge mclk_i);
        bus_i.rd = 1'b1;
        bus_i.addr = a;
        @(posedge mclk_i);
        d = rdata_o;
        @(negedge mclk_i);
        bus_i.rd = 1'b0;
    endtask

    task automatic pulse(ref logic s);
        @(negedge mclk_i);
        s = 1'b1;
        @(negedge mclk_i);
        s = 1'b0;
    endtask

    // Bounded wait for the one-cycle lock pulse; a miss ends the run
    task wait_lock(input int lim, output int cnt);
        cnt = 0;
        do begin
            @(negedge mclk_i);
            cnt++;
            if (cnt > lim) begin
                chk(16'h0000, 16'h0001);
                end_sim;
            end
        end while (lock_irq_o !== 1'b1);
    endtask

    // Bounded wait for a state, counting any lock or unlock flag seen meanwhile
    task wait_state(input scoc_pkg::scoc_state_t s, input int lim, output int cnt, output int fl);
        cnt = 0;
        fl = 0;
        while (state_o !== s) begin
            @(negedge mclk_i);
            cnt++;
            if (lock_irq_o !== 1'b0 || unlock_irq_o !== 1'b0) fl++;
            if (cnt > lim) begin
                chk(16'h0000, 16'h0001);
                end_sim;
            end
        end
    endtask

    task quiet(input int cyc, output int fl);
        fl = 0;
        repeat (cyc) begin
            @(negedge mclk_i);
            if (lock_irq_o !== 1'b0 || unlock_irq_o !== 1'b0) fl++;
        end
    endtask

    task t_reset;
        rd(8'h0a, rv); chk(rv, 8'h17);
        rd(8'h12, rv); chk(rv, 8'hf0);
        rd(8'h13, rv); chk(rv, 8'h00);
        rd(8'h14, rv); chk(rv, 8'h00);
        rd(8'h08, rv); chk(rv, 8'h05);
        rd(8'h3f, rv); chk(rv, 8'h00);
        chk(osc_o.osc_int_on, 1'b1);
        chk(osc_o.osc_ext_ref, 1'b0);
        chk(osc_o.load_cap_trim, 4'h0);
        chk(osc_o.jitter_on, 1'b0);
        chk(synth_en_o, 1'b0);
        chk(state_o, scoc_pkg::SCOC_IDLE);
    endtask

    task t_osc;
        wr(8'h12, 8'h4a);
        chk(osc_o.osc_ext_ref, 1'b1);
        chk(osc_o.osc_int_on, 1'b0);
        chk(osc_o.load_cap_trim, 4'ha);
        // Reserved mode must leave the oscillator as it was, trim still taken
        wr(8'h12, 8'h35);
        chk(osc_o.osc_ext_ref, 1'b1);
        chk(osc_o.load_cap_trim, 4'h5);
        wr(8'h12, 8'hff);
        chk(osc_o.osc_int_on, 1'b1);
        chk(osc_o.load_cap_trim, 4'hf);
    endtask

    task t_jitter;
        wr(8'h0a, 8'h37);
        @(negedge mclk_i);
        chk(osc_o.jitter_on, 1'b1);
        filter_tune_i = 1'b1;
        repeat (2) @(negedge mclk_i);
        chk(osc_o.jitter_on, 1'b0);
        filter_tune_i = 1'b0;
        repeat (2) @(negedge mclk_i);
        chk(osc_o.jitter_on, 1'b1);
    endtask

    task t_lock;
        pulse(go_active_i);
        chk(synth_en_o, 1'b1);
        wait_lock(80, n);
        chk(n >= 48 && n <= 54, 1'b1);
        chk(lock_irq_o, 1'b1);
        @(negedge mclk_i);
        chk(lock_irq_o, 1'b0);
        chk(state_o, scoc_pkg::SCOC_READY);
        chk(synth_freq_o, 14'd9130);
    endtask

    // Address, data and expected transmit frequency; zero means no retune expected
    logic [7:0] ta [18] = '{8'h13, 8'h14, 8'h14, 8'h14, 8'h14, 8'h14, 8'h14, 8'h13, 8'h14,
                            8'h13, 8'h14, 8'h14, 8'h13, 8'h14, 8'h14, 8'h08, 8'h08, 8'h08};
    logic [7:0] td [18] = '{8'h10, 8'h01, 8'h02, 8'h04, 8'h05, 8'h06, 8'h03, 8'h66, 8'h05,
                            8'h67, 8'h04, 8'h07, 8'h5e, 8'h04, 8'h00, 8'h00, 8'h0a, 8'h0b};
    logic [13:0] tf [18] = '{14'd0, 14'd7706, 14'd8586, 14'd7850, 14'd8490, 14'd9036, 14'd9046,
                             14'd9132, 14'd9350, 14'd0, 14'd0, 14'd0, 14'd9270, 14'd8630,
                             14'd9140, 14'd8683, 14'd9240, 14'd0};

    task t_bands;
        logic [13:0] last;
        last = 14'd9140;
        for (int i = 0; i < 18; i++) begin
            wr(ta[i], td[i]);
            if (tf[i] != 14'd0) begin
                wait_lock(700, n);
                chk(n >= 540 && n <= 556, 1'b1);
                last = tf[i];
            end else begin
                quiet(700, hits);
                chk(hits, 0);
            end
            chk(synth_freq_o, last - 14'd10);
        end
        rd(8'h08, rv); chk(rv, 8'h0a);
        rd(8'h14, rv); chk(rv, 8'h00);
        rd(8'h13, rv); chk(rv, 8'h5e);
    endtask

    task t_tx;
        pulse(tx_start_i);
        wait_state(scoc_pkg::SCOC_TXON, 900, n, hits);
        chk(n >= 790 && n <= 800, 1'b1);
        chk(hits, 0);
        chk(tx_ready_o, 1'b1);
        chk(synth_freq_o, 14'd9240);
        chk(osc_o.jitter_on, 1'b0);
        pulse(tx_end_i);
        chk(tx_ready_o, 1'b0);
        wait_state(scoc_pkg::SCOC_READY, 1700, n, hits);
        chk(n >= 1590 && n <= 1600, 1'b1);
        chk(hits, 0);
        chk(synth_freq_o, 14'd9230);
        quiet(4, hits);
        chk(hits, 0);
        chk(osc_o.jitter_on, 1'b1);
    endtask

    task t_idle;
        pulse(go_idle_i);
        chk(state_o, scoc_pkg::SCOC_IDLE);
        chk(synth_en_o, 1'b0);
    endtask

    // A channel change while still locking restarts the settle as a retune
    task t_relock;
        pulse(go_active_i);
        wr(8'h08, 8'h01);
        chk(state_o, scoc_pkg::SCOC_RETUNE);
        wait_lock(700, n);
        chk(n >= 540 && n <= 556, 1'b1);
        chk(state_o, scoc_pkg::SCOC_READY);
        chk(synth_freq_o, 14'd9050);
    endtask

    initial begin
        repeat (3) @(posedge mclk_i);
        @(negedge mclk_i);
        sys_rst_i = 1'b0;
        t_reset;
        t_osc;
        t_jitter;
        t_lock;
        t_bands;
        t_tx;
        t_idle;
        t_relock;
        end_sim;
    end
endmodule
